// [logic/phase_timer_regs.svh]
// Purpose: Constants for the antenna phase sampling timer
// Assumes: ref_clk at 40 MHz
// Notes:   Timing counts derive from the clock and step periods
//
// What this block does
// R1: Measurement unit runs continuously, valid after settling
// R2: Measure driver fall to detector fall
// R3: 64 steps of 125 ns, 6 bit result
// R4: Value is negated phase, 40h per turn
// R5: Phase read returns latest measurement
// R6: Controller computes twice measurement plus offset, masked
// R7: Controller writes separate sampling-time register
// R8: Default offset constant is 3Fh
// R9: Controller runs computation after settling
// R10: Optimisation may rerun any time
// R11: Offsets outside 3Eh..0h are suspect
// R12: Calibration sweeps all 64 offsets
// R13: Maxima lie 10h from minima
// R14: Choose maximum within 30h..0..10h
// R15: Sampling referenced to driver falling edge
// R16: Pulse when step counter equals sampling time
// R17: New sampling time applies at period boundary
`ifndef PHASE_TIMER_REGS_SVH
`define PHASE_TIMER_REGS_SVH
// Clock period and step width in picoseconds
`define CLK_PERIOD_PS 25000
`define STEP_TIME_PS  125000
// Clock cycles per 125 ns step (rounded down; a zero result is rejected by the module's check)
`define STEP_CYCLES   (`STEP_TIME_PS / `CLK_PERIOD_PS)
// Steps per carrier period
`define STEPS_PER_TURN 64
// Reset values
`define PHASE_RESET   6'h00
`define SAMPLE_RESET  6'h00
`endif

// [logic/phase_timer_pkg.sv]
// Purpose: Types for the antenna phase sampling timer
// Assumes: Nothing
// Notes:   Constants live in the header
package phase_timer_pkg;
   // Six-bit step value over one carrier period
   typedef logic [5:0] step_t;
endpackage

// [logic/antenna_phase_sampling_timer.sv]
// Purpose: Phase measurement and sample pulse placement
// Assumes: ref_clk 40 MHz; driver and detector are asynchronous pins
// Notes:   Sampling time command accepted any time, applied at boundary
`timescale 1ns/1ps
`default_nettype none
`include "phase_timer_regs.svh"
module antenna_phase_sampling_timer #(
   parameter int STEP_CYC = `STEP_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              antenna_driver_out,
   input  wire logic              zero_cross_in,
   input  wire logic              phase_read_cmd,
   input  wire logic              sample_write_cmd,
   input  wire phase_timer_pkg::step_t sample_time_in,
   output logic                   phase_read_valid,
   output phase_timer_pkg::step_t phase_read_data,
   output phase_timer_pkg::step_t sample_time_active,
   output logic                   sample_hold_pulse
);

   // The divider is eight bits wide: a step must last 1 to 256 cycles
   if (STEP_CYC < 1 || STEP_CYC > 256) begin : step_cyc_check
      $error("STEP_CYC must lie between 1 and 256");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] drv_sync_reg;   // Driver pin chain
   logic [2:0] zc_sync_reg;    // Detector pin chain
   logic       drv_state_reg;  // Accepted driver level
   logic       zc_state_reg;   // Accepted detector level

   // Three flops per pin; change accepted when last two agree
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         drv_sync_reg  <= 3'h0;
         zc_sync_reg   <= 3'h0;
         drv_state_reg <= 1'b0;
         zc_state_reg  <= 1'b0;
      end else begin
         drv_sync_reg <= {drv_sync_reg[1:0], antenna_driver_out};
         zc_sync_reg  <= {zc_sync_reg[1:0], zero_cross_in};
         if (drv_sync_reg[1] == drv_sync_reg[2]) begin
            drv_state_reg <= drv_sync_reg[2];
         end
         if (zc_sync_reg[1] == zc_sync_reg[2]) begin
            zc_state_reg <= zc_sync_reg[2];
         end
      end
   end

   logic drv_prev_reg;  // Previous accepted driver level
   logic zc_prev_reg;   // Previous accepted detector level
   logic drv_fall;      // Driver falling edge
   logic zc_fall;       // Detector falling edge

   // Edge history
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         drv_prev_reg <= 1'b0;
         zc_prev_reg  <= 1'b0;
      end else begin
         drv_prev_reg <= drv_state_reg;
         zc_prev_reg  <= zc_state_reg;
      end
   end

   // Falling edge from the previous and the present accepted level
   function automatic logic fall_edge(input logic prev_v, input logic now_v);
      return prev_v & ~now_v;
   endfunction

   assign drv_fall = fall_edge(drv_prev_reg, drv_state_reg); // R2
   assign zc_fall  = fall_edge(zc_prev_reg, zc_state_reg);   // R2

   ////////////////////////////////////////////////////////////////////////
   // 125 ns step timebase, restarted on each driver fall
   logic [7:0] div_reg;   // Cycle count within one step
   logic       step_tick; // One-cycle step enable
   phase_timer_pkg::step_t step_reg;  // Steps since driver fall

   assign step_tick = (div_reg == 8'(STEP_CYC - 1));

   // Divider wraps every STEP_CYC cycles; step counter wraps modulo 64
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg  <= 8'h00;
         step_reg <= 6'h00;
      end else if (drv_fall) begin
         div_reg  <= 8'h00; // R15
         step_reg <= 6'h00; // R16
      end else if (step_tick) begin
         div_reg  <= 8'h00;
         step_reg <= step_reg + 6'h01; // R3
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase capture: runs on every carrier period, no enable
   phase_timer_pkg::step_t phase_reg;  // Latest measurement

   // Detector fall stores elapsed steps, truncated, modulo 64
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= `PHASE_RESET;
      end else if (zc_fall) begin
         phase_reg <= step_reg; // R1 R4
      end
   end

   // Phase read answer one cycle after command
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_read_valid <= 1'b0;
         phase_read_data  <= 6'h00;
      end else begin
         phase_read_valid <= phase_read_cmd;
         if (phase_read_cmd) begin
            phase_read_data <= phase_reg; // R5
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sampling time: pending copy, applied at period boundary
   phase_timer_pkg::step_t pend_reg;   // Last written value
   logic                   pend_flag;  // Write not yet applied

   // Write stores pending value; boundary moves it into use
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_reg           <= `SAMPLE_RESET;
         pend_flag          <= 1'b0;
         sample_time_active <= `SAMPLE_RESET;
      end else begin
         if (sample_write_cmd) begin
            pend_reg  <= sample_time_in; // R7
            pend_flag <= 1'b1;
         end else if (drv_fall) begin
            pend_flag <= 1'b0;
         end
         if (drv_fall && pend_flag) begin
            sample_time_active <= pend_reg; // R17
         end
      end
   end

   // Sample pulse registered from the first cycle of the matching step, so it appears one cycle later
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sample_hold_pulse <= 1'b0;
      end else begin
         sample_hold_pulse <= !drv_fall && (div_reg == 8'h00)
                              && (step_reg == sample_time_active); // R16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Every property runs on ref_clk and is silenced while sys_rst is high
   sequence read_req_s;  // Phase read command taken
      phase_read_cmd;
   endsequence

   sequence apply_s;     // Boundary reached with a write waiting
      pend_flag && drv_fall;
   endsequence

   sequence pulse_s;     // Sampling pulse issued
      sample_hold_pulse;
   endsequence

   // Answer follows the command by one cycle with the stored phase
   read_answer_a: assert property (@(posedge ref_clk) // R5
      disable iff (sys_rst) read_req_s |=> phase_read_valid
         && phase_read_data == $past(phase_reg))
      else $error("Phase read answer wrong");

   // Answer never appears without a command one cycle earlier
   read_valid_a: assert property (@(posedge ref_clk) // R5
      disable iff (sys_rst) phase_read_valid |-> $past(phase_read_cmd))
      else $error("Read answer without command");

   // Detector fall stores the step count seen at that edge
   capture_a: assert property (@(posedge ref_clk) // R2
      disable iff (sys_rst) zc_fall |=> phase_reg == $past(step_reg))
      else $error("Phase not captured");

   // Driver fall restarts the divider and the step counter
   step_restart_a: assert property (@(posedge ref_clk) // R15
      disable iff (sys_rst)
      drv_fall |=> step_reg == 6'h00 && div_reg == 8'h00)
      else $error("Step counter not restarted");

   // Step advances once per divider wrap
   step_adv_a: assert property (@(posedge ref_clk) // R3
      disable iff (sys_rst)
      step_tick && !drv_fall |=> step_reg == $past(step_reg) + 6'h01)
      else $error("Step did not advance");

   // Pulse only at the step that matches the sampling time in use
   pulse_match_a: assert property (@(posedge ref_clk) // R16
      disable iff (sys_rst)
      pulse_s |-> $past(step_reg) == $past(sample_time_active))
      else $error("Pulse at wrong step");

   // Pulse lasts a single cycle, so a step is never sampled twice
   pulse_single_a: assert property (@(posedge ref_clk) // R16
      disable iff (sys_rst) pulse_s |=> !sample_hold_pulse)
      else $error("Sample pulse longer than one cycle");

   // Sampling time moves only right after a driver fall
   active_hold_a: assert property (@(posedge ref_clk) // R17
      disable iff (sys_rst)
      !$past(drv_fall) |-> $stable(sample_time_active))
      else $error("Sampling time changed mid period");

   // A waiting write is put in use at the boundary
   apply_a: assert property (@(posedge ref_clk) // R7
      disable iff (sys_rst)
      apply_s |=> sample_time_active == $past(pend_reg))
      else $error("Written time not applied");

   // Phase moves only after a detector fall
   phase_hold_a: assert property (@(posedge ref_clk) // R1
      disable iff (sys_rst) !$past(zc_fall) |-> $stable(phase_reg))
      else $error("Phase changed without edge");

endmodule
`default_nettype wire

// [sim/ctrl_model.sv]
// Purpose: Controller model running one sampling-time update
// Assumes: Requests change 1 ns after the rising edge of ref_clk
// Notes:   Each start runs one read, the calculation, then one write
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
   input  wire logic                   ref_clk,
   input  wire logic                   start,
   input  wire logic                   phase_read_valid,
   input  wire phase_timer_pkg::step_t phase_read_data,
   input  wire logic [5:0]             offset_comp_const,
   output logic                        phase_read_cmd,
   output logic                        sample_write_cmd,
   output phase_timer_pkg::step_t      sample_time_in,
   output phase_timer_pkg::step_t      got_phase,
   output logic                        done
);
   initial begin
      phase_read_cmd   = 1'b0;
      sample_write_cmd = 1'b0;
      sample_time_in   = 6'h00;
      got_phase        = 6'h00;
      done             = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Read the phase, double it, add the offset, keep six bits, write back
   always begin
      @(posedge start);
      done = 1'b0;
      @(posedge ref_clk);
      #1 phase_read_cmd = 1'b1;
      @(posedge ref_clk);
      #1 phase_read_cmd = 1'b0;
      // The answer stands for one cycle only, so it is taken here
      if (phase_read_valid === 1'b1) begin
         got_phase = phase_read_data;
      end
      // Six-bit sum wraps on its own, as the mask would
      sample_time_in   = {got_phase[4:0], 1'b0} + offset_comp_const;
      sample_write_cmd = 1'b1;
      @(posedge ref_clk);
      #1 sample_write_cmd = 1'b0;
      done = 1'b1;
   end
endmodule
`default_nettype wire

// [sim/tb_antenna_phase_sampling_timer.sv]
// Purpose: Self-checking bench for the phase sampling timer
// Assumes: 320 cycles of 25 ns make one carrier period
// Notes:   Detector fall is placed mid-step so truncation is clear
`timescale 1ns/1ps
`default_nettype none
module tb_antenna_phase_sampling_timer;
   logic ref_clk, sys_rst, drv, zc, rd, wr, vld, pulse, start, done;
   phase_timer_pkg::step_t st_in, rdata, active, got;
   int miscompares, tests_run, cyc, dly;
   logic [5:0] offset_comp_const; // Offset used by the controller model
   antenna_phase_sampling_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .antenna_driver_out(drv), .zero_cross_in(zc), .phase_read_cmd(rd),
      .sample_write_cmd(wr), .sample_time_in(st_in),
      .phase_read_valid(vld), .phase_read_data(rdata),
      .sample_time_active(active), .sample_hold_pulse(pulse));
   ctrl_model ctrl (.ref_clk(ref_clk), .start(start),
      .offset_comp_const(offset_comp_const),
      .phase_read_valid(vld), .phase_read_data(rdata),
      .phase_read_cmd(rd), .sample_write_cmd(wr), .sample_time_in(st_in),
      .got_phase(got), .done(done));
   ////////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Driver falls at cycle 0, detector falls dly cycles later
   always @(posedge ref_clk) begin
      #1 cyc = (cyc + 1) % 320;
      drv = (cyc >= 160);
      zc  = (((cyc - dly + 320) % 320) >= 160);
   end
   task automatic check(input logic [9:0] got_v, input logic [9:0] exp_v);
      tests_run++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Start one controller update and wait, bounded, for it to finish
   task automatic start_update;
      int n;
      #2 start = 1'b1;
      @(posedge ref_clk);
      #2 start = 1'b0;
      for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge ref_clk);
      if (n == 20) begin
         miscompares++;
         end_of_test();
      end
   endtask
   // Sweep all offsets at the nominal delay, then place the chosen one
   task automatic calib_sweep;
      logic [5:0] min_a, min_b, max_a, max_b, pick;
      int off;
      dly = 8'h13 * 5 + 2;
      repeat (960) @(posedge ref_clk);
      for (off = 0; off < 64; off++) begin
         offset_comp_const = 6'(off);
         start_update();
         check(10'(got), 10'h013);
         repeat (330) @(posedge ref_clk);
         #2 check(10'(active), 10'((2 * 8'h13 + off) % 64));
      end
      // No demodulator here, so the minima of a typical sweep are given
      min_a = 6'h2e;
      min_b = 6'h0e;
      max_a = min_a + 6'h10;
      max_b = min_b + 6'h10;
      // Keep the maximum in the wrap-around window from 30h through 10h
      pick = (max_a >= 6'h30 || max_a <= 6'h10) ? max_a : max_b;
      // An offset outside 3Eh to 0h is suspect: use the typical one
      if (!(pick >= 6'h3e || pick == 6'h00)) pick = 6'h3f;
      offset_comp_const = pick;
      start_update();
      repeat (330) @(posedge ref_clk);
      #2 check(10'(active), 10'((2 * 8'h13 + pick) % 64));
      offset_comp_const = 6'h3f;
   endtask
   // Full update at a given step delay, then the pulse over one period
   task automatic run_delay(input logic [5:0] d);
      logic [5:0] st_exp;
      int n, cnt, pos;
      st_exp = 6'((2 * d + 8'h3f) % 64);
      dly = d * 5 + 2;
      repeat (960) @(posedge ref_clk);
      start_update();
      check(10'(got), 10'(d));
      repeat (700) @(posedge ref_clk);
      #2 check(10'(active), 10'(st_exp));
      cnt = 0;
      pos = 0;
      for (n = 0; n < 320; n++) begin
         @(posedge ref_clk);
         #2 if (pulse === 1'b1) begin
            cnt++;
            pos = (cyc - st_exp * 5 + 320) % 320;
         end
      end
      check(10'(cnt), 10'h001);
      check(10'(pos < 10), 10'h001);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset for five cycles, then nominal, zero and top-step delays
   initial begin
      miscompares = 0;
      tests_run = 0;
      cyc = 0;
      dly = 0;
      drv = 1'b0;
      zc = 1'b0;
      start = 1'b0;
      offset_comp_const = 6'h3f;
      sys_rst = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check(10'(active), 10'h000);
      run_delay(6'h13);
      run_delay(6'h00);
      run_delay(6'h3f);
      calib_sweep();
      end_of_test();
   end
endmodule
`default_nettype wire
